// >>> logic/source_status_regs.vh
// Register offsets, field positions and reset values of the source status bank
`ifndef SOURCE_STATUS_REGS_VH
`define SOURCE_STATUS_REGS_VH

// Byte offsets on the register bus
`define OFS_STATUS          4'h0
`define OFS_PATH_SELECT     4'h4
`define OFS_SOURCE_ENABLE   4'h8
`define OFS_REMOTE_DISABLE  4'hC

// Status field positions
`define STS_HIGHEST_MSB     7
`define STS_HIGHEST_LSB     4
`define STS_SELECTED_MSB    3
`define STS_SELECTED_LSB    0

// Path select field position
`define PATH_SELECT_BIT     4

// Source codes
`define CODE_NONE           4'h0

// Reset values
`define RST_STATUS          8'h00
`define RST_PATH_SELECT     1'b0
`define RST_SOURCE_ENABLE   14'h3fff
`define RST_REMOTE_DISABLE  14'h0000
`define RST_READDATA        32'h0000_0000

`endif

// >>> logic/highest_priority_pick.v
// Picks the allowed input with the best priority and returns its channel code
`timescale 1ns/1ps
`default_nettype none
`include "source_status_regs.vh"

module highest_priority_pick #(
  parameter CHANNELS = 14
) (
  // Candidate inputs
  input  wire [CHANNELS-1:0]   i_allowed,
  input  wire [CHANNELS*4-1:0] i_priority,
  // Result
  output wire [3:0]            o_code
);

  wire [3:0] best_code [0:CHANNELS];
  wire [3:0] best_prio [0:CHANNELS];

  assign best_code[0] = `CODE_NONE;
  assign best_prio[0] = 4'h0;

  // Smaller priority value wins; priority zero keeps an input out of the table
  // Ties go to the lower channel, so the choice is stable
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chain
      localparam integer CHANNEL_CODE = ch + 1;
      wire [3:0] prio = i_priority[ch*4 +: 4];
      wire       take = i_allowed[ch] && (prio != 4'h0) &&
                        ((best_prio[ch] == 4'h0) || (prio < best_prio[ch]));
      assign best_code[ch+1] = take ? CHANNEL_CODE[3:0] : best_code[ch];
      assign best_prio[ch+1] = take ? prio : best_prio[ch];
    end
  endgenerate

  assign o_code = best_code[CHANNELS];

endmodule
`default_nettype wire

// >>> logic/source_status.v
// Reference source status register bank with its Avalon-MM slave
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "source_status_regs.vh"

module source_status #(
  parameter CHANNELS = 14
) (
  // Clock and reset
  input  wire                  i_clk_sys,
  input  wire                  i_rst,
  // Avalon-MM slave
  input  wire [3:0]            i_address,
  input  wire                  i_read,
  input  wire                  i_write,
  input  wire [31:0]           i_writedata,
  input  wire [3:0]            i_byteenable,
  output reg  [31:0]           o_readdata,
  output reg                   o_waitrequest,
  // Validation results per path
  input  wire [CHANNELS-1:0]   i_valid_primary,
  input  wire [CHANNELS-1:0]   i_valid_secondary,
  // Priority tables per path, four bits per input
  input  wire [CHANNELS*4-1:0] i_priority_primary,
  input  wire [CHANNELS*4-1:0] i_priority_secondary,
  // Selection made by the primary path state machine
  input  wire [3:0]            i_selected_primary,
  // Inputs allowed to take part in selection
  output reg  [CHANNELS-1:0]   o_allowed
);

  reg                 path_report_select;
  reg  [CHANNELS-1:0] source_enable;
  reg  [CHANNELS-1:0] remote_disable;
  reg  [7:0]          status;

  wire [CHANNELS-1:0] allowed_now;
  wire [CHANNELS-1:0] allowed_primary;
  wire [CHANNELS-1:0] allowed_secondary;
  wire [3:0]          highest_primary;
  wire [3:0]          highest_secondary;
  wire                selected_known;
  wire                selected_in_range;
  wire [3:0]          selected_primary;
  wire [7:0]          next_status;
  wire                request;
  wire                accept;
  reg  [31:0]         next_readdata;
  reg  [3:0]          next_highest;
  reg  [3:0]          next_selected;
  wire                read_take;
  wire                write_take;

  // Inputs barred by software drop out of both fields
  assign allowed_now       = source_enable & ~remote_disable;
  assign allowed_primary   = i_valid_primary & allowed_now;
  assign allowed_secondary = i_valid_secondary & allowed_now;

  highest_priority_pick #(
    .CHANNELS (CHANNELS)
  ) u_pick_primary (
    .i_allowed  (allowed_primary),
    .i_priority (i_priority_primary),
    .o_code     (highest_primary)
  );

  highest_priority_pick #(
    .CHANNELS (CHANNELS)
  ) u_pick_secondary (
    .i_allowed  (allowed_secondary),
    .i_priority (i_priority_secondary),
    .o_code     (highest_secondary)
  );

  // The primary selection is shown as given, even when it is not the best
  // input, because non-revertive mode does not switch back on its own
  // The range test keeps the index below from running past the vector
  assign selected_in_range = (i_selected_primary != `CODE_NONE) &&
                             (i_selected_primary <= CHANNELS);
  assign selected_known    = selected_in_range &&
                             allowed_primary[i_selected_primary - 4'h1];
  assign selected_primary  = selected_known ? i_selected_primary
                                            : `CODE_NONE;

  // Secondary path has no non-revertive mode, so its selection is its best
  always @*
  begin
    next_highest  = `CODE_NONE;
    next_selected = `CODE_NONE;
    case (path_report_select)
      1'b0:
      begin
        next_highest  = highest_primary;
        next_selected = selected_primary;
      end
      1'b1:
      begin
        next_highest  = highest_secondary;
        next_selected = highest_secondary;
      end
      default:
      begin
        next_highest  = `CODE_NONE;
        next_selected = `CODE_NONE;
      end
    endcase
  end

  assign next_status = {next_highest, next_selected};

  // Status is refreshed every cycle and never written by software
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      status    <= `RST_STATUS;
      o_allowed <= {CHANNELS{1'b0}};
    end
    else
    begin
      status[`STS_HIGHEST_MSB:`STS_HIGHEST_LSB]   <=
        next_status[`STS_HIGHEST_MSB:`STS_HIGHEST_LSB];
      status[`STS_SELECTED_MSB:`STS_SELECTED_LSB] <=
        next_status[`STS_SELECTED_MSB:`STS_SELECTED_LSB];
      // Registered copy; it lags a mask write by one cycle
      o_allowed <= allowed_now;
    end
  end

  // One wait state: waitrequest drops for the second cycle of a request.
  // Costs a cycle per access but keeps read data straight from a flop.
  assign request    = i_read | i_write;
  assign accept     = request & ~o_waitrequest;
  assign read_take  = i_read & o_waitrequest;
  assign write_take = accept & i_write;

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= ~(request & o_waitrequest);
  end

  // Read mux; unmapped offsets read as zero
  always @*
  begin
    next_readdata = `RST_READDATA;
    case (i_address)
      `OFS_STATUS:
        next_readdata[7:0] = status;
      `OFS_PATH_SELECT:
        next_readdata[`PATH_SELECT_BIT] = path_report_select;
      `OFS_SOURCE_ENABLE:
        next_readdata[CHANNELS-1:0] = source_enable;
      `OFS_REMOTE_DISABLE:
        next_readdata[CHANNELS-1:0] = remote_disable;
      default:
        next_readdata = `RST_READDATA;
    endcase
  end

  // Read data is captured while waitrequest is high so that it stands at
  // the edge where the master takes it; reading has no side effect
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_readdata <= `RST_READDATA;
    else if (read_take)
      o_readdata <= next_readdata;
  end

  // Writable configuration; the status offset is not decoded for writes
  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      path_report_select <= `RST_PATH_SELECT;
      source_enable      <= `RST_SOURCE_ENABLE;
      remote_disable     <= `RST_REMOTE_DISABLE;
    end
    // Byte lanes 2 and 3 hold no register bits and are ignored
    else if (write_take)
    begin
      case (i_address)
        `OFS_PATH_SELECT:
        begin
          if (i_byteenable[0])
            path_report_select <= i_writedata[`PATH_SELECT_BIT];
        end
        `OFS_SOURCE_ENABLE:
        begin
          if (i_byteenable[0])
            source_enable[7:0] <= i_writedata[7:0];
          if (i_byteenable[1])
            source_enable[CHANNELS-1:8] <= i_writedata[CHANNELS-1:8];
        end
        `OFS_REMOTE_DISABLE:
        begin
          if (i_byteenable[0])
            remote_disable[7:0] <= i_writedata[7:0];
          if (i_byteenable[1])
            remote_disable[CHANNELS-1:8] <= i_writedata[CHANNELS-1:8];
        end
        default:
          path_report_select <= path_report_select;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verification/source_status_assertions.sv
// Bus timing and status field checks for the source status bank
`timescale 1ns/1ps
`default_nettype none
module source_status_assertions #(
  parameter CHANNELS = 14
) (
  // Clock, reset and bus
  input wire logic                i_clk_sys,
  input wire logic                i_rst,
  input wire logic [3:0]          i_address,
  input wire logic                i_read,
  input wire logic                i_write,
  input wire logic [31:0]         o_readdata,
  input wire logic                o_waitrequest,
  // Source state
  input wire logic [CHANNELS-1:0] i_valid_primary,
  input wire logic [CHANNELS-1:0] i_valid_secondary,
  input wire logic [CHANNELS-1:0] o_allowed
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire logic take = i_read && o_waitrequest;
  AST_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no accept after request");
  AST_WAIT_BACK: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("accept held too long");
  AST_IDLE_WAIT: assert property (!i_read && !i_write |=> o_waitrequest)
    else $error("accept without request");
  AST_NO_SOURCE: assert property (take && i_address == 4'h0 && $past(i_valid_primary) == 0
    && $past(i_valid_secondary) == 0 |=> o_readdata[7:0] == 8'h00)
    else $error("status not empty");
  AST_RESERVED: assert property (take && i_address == 4'h0 |=> o_readdata[31:8] == 24'h0)
    else $error("status upper bits set");
  AST_UNMAPPED: assert property (take && i_address[1:0] != 2'b00 |=> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_HOLD_DATA: assert property (!take |=> $stable(o_readdata))
    else $error("read data moved");
  // Mask reset value must reach the allowed set soon after release
  AST_ALLOW_RST: assert property ($past(i_rst) |-> ##[1:2] &o_allowed)
    else $error("allowed set wrong after reset");
  cover property (take && i_address == 4'h0 ##1 o_readdata[7:4] != 4'h0);
  cover property (i_write && !o_waitrequest);
  cover property (take && i_address == 4'h2);
endmodule
bind source_status source_status_assertions #(.CHANNELS(CHANNELS)) u_assertions (
  .i_clk_sys         (i_clk_sys),
  .i_rst             (i_rst),
  .i_address         (i_address),
  .i_read            (i_read),
  .i_write           (i_write),
  .o_readdata        (o_readdata),
  .o_waitrequest     (o_waitrequest),
  .i_valid_primary   (i_valid_primary),
  .i_valid_secondary (i_valid_secondary),
  .o_allowed         (o_allowed)
);
`default_nettype wire

// >>> verification/tb_source_status.sv
// Self-checking bench for the source status bank
`timescale 1ns/1ps
`default_nettype none
module tb_source_status;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_address = 4'h0;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0]  i_byteenable = 4'hf;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic [13:0] i_valid_primary = 14'h0;
  logic [13:0] i_valid_secondary = 14'h0;
  logic [55:0] i_priority_primary = 56'h0;
  logic [55:0] i_priority_secondary = 56'h0;
  logic [3:0]  i_selected_primary = 4'h0;
  logic [13:0] o_allowed;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          comparisons = 0;
  source_status dut (
    .i_clk_sys            (i_clk_sys),
    .i_rst                (i_rst),
    .i_address            (i_address),
    .i_read               (i_read),
    .i_write              (i_write),
    .i_writedata          (i_writedata),
    .i_byteenable         (i_byteenable),
    .o_readdata           (o_readdata),
    .o_waitrequest        (o_waitrequest),
    .i_valid_primary      (i_valid_primary),
    .i_valid_secondary    (i_valid_secondary),
    .i_priority_primary   (i_priority_primary),
    .i_priority_secondary (i_priority_secondary),
    .i_selected_primary   (i_selected_primary),
    .o_allowed            (o_allowed)
  );
  always #50 i_clk_sys = ~i_clk_sys;
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request rises after an edge and is held until waitrequest is seen low
  task automatic bus(input logic w, input [3:0] a, input [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_address <= a;
    i_read <= !w;
    i_write <= w;
    i_writedata <= wd;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (o_waitrequest && n < 20);
    rdata = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (o_waitrequest)
    begin
      num_errors++;
      $display("CHECK FAILED waitrequest expected 0 seen 1");
      test_done();
    end
  endtask
  task automatic rd(input [3:0] a, input [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  // Input n gets the best priority, all others tie one step behind
  function automatic [55:0] pri(input int n);
    for (int i = 0; i < 14; i++)
      pri[4*i +: 4] = (i == n - 1) ? 4'h1 : 4'h2;
  endfunction
  task automatic t_reset_values;
    rd(4'h4, 32'h0, "path");
    rd(4'h8, 32'h3fff, "enable");
    rd(4'hc, 32'h0, "disable");
    rd(4'h0, 32'h0, "empty");
  endtask
  // Selection stays on input 2 while the best input sweeps past it
  task automatic t_sweep;
    i_valid_primary <= 14'h3fff;
    i_selected_primary <= 4'h2;
    for (int n = 1; n <= 14; n++)
    begin
      i_priority_primary <= pri(n);
      rd(4'h0, 32'(n * 16 + 2), "primary");
    end
  endtask
  task automatic t_secondary;
    i_valid_secondary <= 14'h3fff;
    i_priority_secondary <= pri(9);
    bus(1'b1, 4'h4, 32'h10);
    rd(4'h0, 32'h99, "secondary");
    i_valid_secondary <= 14'h0;
    rd(4'h0, 32'h0, "sec empty");
    bus(1'b1, 4'h4, 32'h0);
    rd(4'h0, 32'he2, "primary back");
  endtask
  task automatic t_disallowed;
    i_priority_primary <= pri(7);
    i_selected_primary <= 4'h7;
    rd(4'h0, 32'h77, "best");
    bus(1'b1, 4'hc, 32'h40);
    rd(4'h0, 32'h10, "remote off");
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b1, 4'h8, 32'h3fbf);
    repeat (2) @(posedge i_clk_sys);
    chk("allowed", 32'h3fbf, {18'h0, o_allowed});
    rd(4'h0, 32'h10, "enable off");
    bus(1'b1, 4'h8, 32'h3fff);
    bus(1'b1, 4'h0, 32'hff);
    rd(4'h0, 32'h77, "ro status");
    rd(4'h2, 32'h0, "unmapped");
  endtask
  // Byte enables gate each lane of a write
  task automatic t_lanes;
    i_byteenable <= 4'h1;
    bus(1'b1, 4'h8, 32'h3f00);
    rd(4'h8, 32'h3f00, "enable lane 0");
    i_byteenable <= 4'h2;
    bus(1'b1, 4'h8, 32'h00ff);
    rd(4'h8, 32'h0, "enable lane 1");
    bus(1'b1, 4'h4, 32'h10);
    rd(4'h4, 32'h0, "path lane 1");
    i_byteenable <= 4'hf;
    bus(1'b1, 4'h8, 32'h3fff);
    rd(4'h8, 32'h3fff, "enable back");
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset_values();
    t_sweep();
    t_secondary();
    t_disallowed();
    t_lanes();
    test_done();
  end
endmodule
`default_nettype wire
